// *** hdl/sesp_cond.sv ***
// start and stop detection on the data line edges
// assumes reset is held over at least one start and one stop of the bus
`timescale 1ns/1ns
module sesp_cond (
  // bus lines and reset
  input wire logic i_sda,
  input wire logic i_scl,
  input wire logic i_rst_n,
  // one toggle per condition
  output logic o_start_tog,
  output logic o_stop_tog
);
  logic start_reg;
  logic start_next;
  logic stop_reg;
  logic stop_next;

  // data falling while the clock is high is a start, rising is a stop
  always_comb begin
    start_next = i_rst_n ? (start_reg ^ i_scl) : 1'b0;
    stop_next = i_rst_n ? (stop_reg ^ i_scl) : 1'b0;
  end

  always_ff @(negedge i_sda) begin
    start_reg <= start_next;
  end

  always_ff @(posedge i_sda) begin
    stop_reg <= stop_next;
  end

  assign o_start_tog = start_reg;
  assign o_stop_tog = stop_reg;
endmodule // sesp_cond

// *** hdl/sesp_pkg.sv ***
// constants, states and carriers for the serial eeprom slave protocol block
// assumes a 20 MHz core clock; the serial clock comes from the bus master
package sesp_pkg;

  // timing
  localparam int CLK_HZ = 20_000_000;
  localparam int TWC_MS = 5;
  localparam int TWC_CYCLES = TWC_MS * (CLK_HZ / 1000);
  localparam int COPY_CYCLES = 16;

  // array geometry and protection
  localparam int PAGE_BYTES = 16;
  localparam int ARRAY_BYTES = 256;
  localparam logic [7:0] LOWER_HALF_TOP = 8'h7F;
  localparam logic SWP_RESET = 1'b0;

  // control codes, upper nibble of the control byte
  localparam logic [3:0] CODE_PROT = 4'h6;
  localparam logic [3:0] CODE_FUSE = 4'h9;

  // bit counter marks
  localparam logic [3:0] BIT_LAST = 4'h7;
  localparam logic [3:0] BIT_ACK = 4'h8;

  typedef enum logic [1:0] {CMD_NONE, CMD_ARRAY, CMD_SETPROT, CMD_FUSE} sesp_cmd_e;
  typedef enum logic [2:0] {LK_IDLE, LK_CTRL, LK_ADDR, LK_DATA, LK_READ, LK_SKIP} sesp_link_e;
  typedef enum logic [1:0] {CR_IDLE, CR_COPY, CR_WAIT} sesp_core_e;

  // write command waiting for the stop that commits it
  typedef struct packed {
    sesp_cmd_e kind;
    logic [3:0] page;
    logic [15:0] mask;
  } sesp_commit_s;

  // levels seen by the link side
  typedef struct packed {
    logic busy;
    logic swp;
    logic hv;
    logic [2:0] cs;
  } sesp_link_in_s;

endpackage

// *** hdl/sesp_sync3.sv ***
// three-stage level synchroniser with agreement filter
// assumes the input is a level that stays put for several destination edges
`timescale 1ns/1ns
module sesp_sync3 #(
  parameter int W = 1
) (
  // destination clock
  input wire logic i_clk,
  input wire logic i_rst_n,
  // level in and filtered level out
  input wire logic [W-1:0] i_d,
  output logic [W-1:0] o_q
);
  logic [W-1:0] f1_reg;
  logic [W-1:0] f2_reg;
  logic [W-1:0] f3_reg;
  logic [W-1:0] q_reg;
  logic [W-1:0] q_next;

  // a change counts only once the last two stages agree
  always_comb begin
    q_next = (f2_reg == f3_reg) ? f3_reg : q_reg;
  end

  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      f1_reg <= '0;
      f2_reg <= '0;
      f3_reg <= '0;
      q_reg <= '0;
    end else begin
      f1_reg <= i_d;
      f2_reg <= f1_reg;
      f3_reg <= f2_reg;
      q_reg <= q_next;
    end
  end

  assign o_q = q_reg;
endmodule // sesp_sync3

// *** hdl/sesp_top.sv ***
// two-wire slave command logic of a 256-byte eeprom with write protection
// assumes a master drives the serial clock; the array is read across domains
// only while no programming cycle runs, so it is stable at that time
`timescale 1ns/1ns
////////////////////////////////////////////////////////////////////////////////
module sesp_top #(
  // memory operation code; any value except CODE_PROT and CODE_FUSE
  parameter logic [3:0] MEM_CODE = 4'h5,
  parameter int PROG_CYCLES = sesp_pkg::TWC_CYCLES
) (
  // core clock and reset
  input wire logic i_clock,
  input wire logic i_rst_n,
  // serial link
  input wire logic i_scl,
  input wire logic i_sda_in,
  output logic o_sda_out,
  output logic o_sda_oe,
  // pins
  input wire logic i_chip_select_bit0,
  input wire logic i_chip_select_bit1,
  input wire logic i_chip_select_bit2,
  input wire logic i_write_protect,
  input wire logic i_wp_high_voltage,
  // status
  output logic o_busy,
  output logic o_sw_protect
);
  localparam int WAIT_LAST = PROG_CYCLES - sesp_pkg::COPY_CYCLES - 1;

  logic start_tog;
  logic stop_tog;
  logic stop_s;
  logic wp_s;
  sesp_pkg::sesp_link_in_s lin_raw;
  sesp_pkg::sesp_link_in_s lin_s;
  sesp_pkg::sesp_link_e state_reg, state_next;
  logic [3:0] cnt_reg, cnt_next;
  logic [7:0] sh_reg, sh_next;
  logic [7:0] rd_reg, rd_next;
  logic [7:0] ptr_reg, ptr_next;
  logic [7:0] byte_in;
  logic [7:0] mem_rd;
  logic ack_reg, ack_next;
  logic seen_reg, seen_next;
  logic buf_we;
  logic oe_reg, oe_next;
  logic out_reg;
  sesp_pkg::sesp_cmd_e cmd_reg, cmd_next;
  sesp_pkg::sesp_commit_s pend_reg, pend_next;
  sesp_pkg::sesp_commit_s cur_reg, cur_next;
  sesp_pkg::sesp_core_e core_reg, core_next;
  logic [3:0] idx_reg, idx_next;
  logic [31:0] tmr_reg, tmr_next;
  logic busy_reg, busy_next;
  logic swp_reg, swp_next;
  logic stop_seen_reg;
  logic stop_evt;
  logic mem_we;
  logic [7:0] waddr;
  logic [7:0] page_buf [sesp_pkg::PAGE_BYTES];
  logic [7:0] mem [sesp_pkg::ARRAY_BYTES];
  int busy_len;

  function automatic sesp_pkg::sesp_cmd_e cmd_of(input logic [3:0] code, input logic [3:0] mcode);
    if (code == mcode) begin
      return sesp_pkg::CMD_ARRAY;
    end else if (code == sesp_pkg::CODE_PROT) begin
      return sesp_pkg::CMD_SETPROT;
    end else if (code == sesp_pkg::CODE_FUSE) begin
      return sesp_pkg::CMD_FUSE;
    end
    return sesp_pkg::CMD_NONE;
  endfunction

  function automatic logic accept(input logic [7:0] b, input sesp_pkg::sesp_link_in_s li, input logic [3:0] mcode);
    logic ok;
    ok = 1'b0;
    case (cmd_of(b[7:4], mcode))
      sesp_pkg::CMD_ARRAY: ok = 1'b1;
      sesp_pkg::CMD_SETPROT: ok = !b[0] && !li.swp;
      sesp_pkg::CMD_FUSE: ok = !b[0] && li.hv;
      default: ok = 1'b0;
    endcase
    return ok && (b[3:1] == li.cs) && !li.busy;
  endfunction

  ////////////////////////////////////////////////////////////////////////////////
  // link side, clocked by the serial clock
  sesp_cond u_cond (
    .i_sda(i_sda_in),
    .i_scl(i_scl),
    .i_rst_n(i_rst_n),
    .o_start_tog(start_tog),
    .o_stop_tog(stop_tog)
  );

  assign lin_raw = '{busy: busy_reg, swp: swp_reg, hv: i_wp_high_voltage,
                     cs: {i_chip_select_bit2, i_chip_select_bit1, i_chip_select_bit0}};

  sesp_sync3 #(.W(6)) u_link_sync (
    .i_clk(i_scl),
    .i_rst_n(i_rst_n),
    .i_d(lin_raw),
    .o_q(lin_s)
  );

  assign mem_rd = mem[ptr_reg];

  always_comb begin
    byte_in = {sh_reg[6:0], i_sda_in};
    state_next = state_reg;
    cnt_next = cnt_reg;
    sh_next = sh_reg;
    ack_next = ack_reg;
    rd_next = rd_reg;
    ptr_next = ptr_reg;
    cmd_next = cmd_reg;
    pend_next = pend_reg;
    seen_next = start_tog;
    buf_we = 1'b0;
    if (start_tog != seen_reg) begin
      state_next = sesp_pkg::LK_CTRL;
      cnt_next = 4'h1;
      sh_next = {7'h00, i_sda_in};
      ack_next = 1'b0;
      pend_next = '0;
    end else begin
      case (state_reg)
        sesp_pkg::LK_CTRL, sesp_pkg::LK_ADDR, sesp_pkg::LK_DATA: begin
          if (cnt_reg != sesp_pkg::BIT_ACK) begin
            sh_next = byte_in;
            cnt_next = cnt_reg + 4'h1;
            if (cnt_reg == sesp_pkg::BIT_LAST) begin
              ack_next = (state_reg == sesp_pkg::LK_CTRL) ? accept(byte_in, lin_s, MEM_CODE) : !lin_s.busy;
            end
          end else begin
            cnt_next = 4'h0;
            ack_next = 1'b0;
            if (!ack_reg) begin
              state_next = sesp_pkg::LK_SKIP;
            end else if (state_reg == sesp_pkg::LK_CTRL) begin
              if (sh_reg[0]) begin
                state_next = sesp_pkg::LK_READ;
                rd_next = mem_rd;
                ptr_next = ptr_reg + 8'h01;
              end else begin
                state_next = sesp_pkg::LK_ADDR;
                cmd_next = cmd_of(sh_reg[7:4], MEM_CODE);
              end
            end else if (state_reg == sesp_pkg::LK_ADDR) begin
              state_next = sesp_pkg::LK_DATA;
              if (cmd_reg == sesp_pkg::CMD_ARRAY) begin
                ptr_next = sh_reg;
              end
            end else begin
              // data taken, commit waits for stop
              pend_next.kind = cmd_reg;
              pend_next.page = ptr_reg[7:4];
              if (cmd_reg == sesp_pkg::CMD_ARRAY) begin
                buf_we = 1'b1;
                pend_next.mask[ptr_reg[3:0]] = 1'b1;
                ptr_next = {ptr_reg[7:4], ptr_reg[3:0] + 4'h1};
              end
            end
          end
        end
        sesp_pkg::LK_READ: begin
          if (cnt_reg != sesp_pkg::BIT_ACK) begin
            cnt_next = cnt_reg + 4'h1;
          end else begin
            cnt_next = 4'h0;
            if (!i_sda_in) begin
              rd_next = mem_rd;
              ptr_next = ptr_reg + 8'h01;
            end else begin
              state_next = sesp_pkg::LK_SKIP;
            end
          end
        end
        default: begin
        end
      endcase
    end
  end

  always_ff @(posedge i_scl) begin
    if (!i_rst_n) begin
      state_reg <= sesp_pkg::LK_IDLE;
      cnt_reg <= 4'h0;
      sh_reg <= 8'h00;
      ack_reg <= 1'b0;
      rd_reg <= 8'h00;
      ptr_reg <= 8'h00;
      cmd_reg <= sesp_pkg::CMD_NONE;
      pend_reg <= '0;
      seen_reg <= 1'b0;
    end else begin
      state_reg <= state_next;
      cnt_reg <= cnt_next;
      sh_reg <= sh_next;
      ack_reg <= ack_next;
      rd_reg <= rd_next;
      ptr_reg <= ptr_next;
      cmd_reg <= cmd_next;
      pend_reg <= pend_next;
      seen_reg <= seen_next;
    end
  end

  always_ff @(posedge i_scl) begin
    if (buf_we) begin
      page_buf[ptr_reg[3:0]] <= sh_reg;
    end
  end

  // data changes only while the clock is low
  always_comb begin
    if (!i_rst_n) begin
      oe_next = 1'b0;
    end else if (state_reg == sesp_pkg::LK_READ) begin
      oe_next = (cnt_reg != sesp_pkg::BIT_ACK) && !rd_reg[~cnt_reg[2:0]];
    end else begin
      oe_next = ack_reg;
    end
  end

  always_ff @(negedge i_scl) begin
    oe_reg <= oe_next;
    out_reg <= 1'b0;
  end

  assign o_sda_oe = oe_reg;
  assign o_sda_out = out_reg;

  ////////////////////////////////////////////////////////////////////////////////
  // programming engine, core clock
  sesp_sync3 #(.W(2)) u_core_sync (
    .i_clk(i_clock),
    .i_rst_n(i_rst_n),
    .i_d({stop_tog, i_write_protect}),
    .o_q({stop_s, wp_s})
  );

  // link registers are sampled after stop, while the bus is quiet
  always_comb begin
    stop_evt = (stop_s != stop_seen_reg);
    core_next = core_reg;
    cur_next = cur_reg;
    idx_next = idx_reg;
    tmr_next = tmr_reg;
    busy_next = busy_reg;
    swp_next = swp_reg;
    waddr = {cur_reg.page, idx_reg};
    mem_we = 1'b0;
    case (core_reg)
      sesp_pkg::CR_IDLE: begin
        if (stop_evt && pend_reg.kind != sesp_pkg::CMD_NONE) begin
          cur_next = pend_reg;
          core_next = sesp_pkg::CR_COPY;
          idx_next = 4'h0;
          busy_next = 1'b1;
        end
      end
      sesp_pkg::CR_COPY: begin
        if (cur_reg.kind == sesp_pkg::CMD_ARRAY && cur_reg.mask[idx_reg] && !wp_s
            && !(swp_reg && waddr <= sesp_pkg::LOWER_HALF_TOP)) begin
          mem_we = 1'b1;
        end
        if (idx_reg == 4'hF) begin
          core_next = sesp_pkg::CR_WAIT;
          tmr_next = 32'h0000_0000;
          if (cur_reg.kind == sesp_pkg::CMD_SETPROT && !wp_s) begin
            swp_next = 1'b1;
          end
          if (cur_reg.kind == sesp_pkg::CMD_FUSE) begin
            swp_next = 1'b0;
          end
        end else begin
          idx_next = idx_reg + 4'h1;
        end
      end
      sesp_pkg::CR_WAIT: begin
        if (tmr_reg == 32'(WAIT_LAST)) begin
          core_next = sesp_pkg::CR_IDLE;
          busy_next = 1'b0;
        end else begin
          tmr_next = tmr_reg + 32'h0000_0001;
        end
      end
      default: core_next = sesp_pkg::CR_IDLE;
    endcase
  end

  always_ff @(posedge i_clock) begin
    if (!i_rst_n) begin
      core_reg <= sesp_pkg::CR_IDLE;
      cur_reg <= '0;
      idx_reg <= 4'h0;
      tmr_reg <= 32'h0000_0000;
      busy_reg <= 1'b0;
      swp_reg <= sesp_pkg::SWP_RESET;
      stop_seen_reg <= 1'b0;
    end else begin
      core_reg <= core_next;
      cur_reg <= cur_next;
      idx_reg <= idx_next;
      tmr_reg <= tmr_next;
      busy_reg <= busy_next;
      swp_reg <= swp_next;
      stop_seen_reg <= stop_s;
    end
  end

  always_ff @(posedge i_clock) begin
    if (mem_we) begin
      mem[waddr] <= page_buf[idx_reg];
    end
  end

  assign o_busy = busy_reg;
  assign o_sw_protect = swp_reg;

  ////////////////////////////////////////////////////////////////////////////////
  // checks
  always_ff @(posedge i_clock) begin
    busy_len <= (!i_rst_n || !busy_reg) ? 0 : busy_len + 1;
  end

  cycle_len_a: assert property (@(posedge i_clock) disable iff (!i_rst_n)
    $fell(busy_reg) |-> busy_len == PROG_CYCLES) else $error("programming cycle length wrong");
  stop_prog_a: assert property (@(posedge i_clock) disable iff (!i_rst_n)
    core_reg == sesp_pkg::CR_IDLE && stop_evt && pend_reg.kind != sesp_pkg::CMD_NONE |=> busy_reg[*8])
    else $error("stop did not start programming");
  wp_block_a: assert property (@(posedge i_clock) disable iff (!i_rst_n)
    mem_we |-> !wp_s && !$rose(swp_reg)) else $error("write while pin protected");
  swp_lower_a: assert property (@(posedge i_clock) disable iff (!i_rst_n)
    mem_we && swp_reg |-> waddr[7]) else $error("lower half written while protected");
  fuse_only_a: assert property (@(posedge i_clock) disable iff (!i_rst_n)
    $fell(swp_reg) |-> $past(cur_reg.kind) == sesp_pkg::CMD_FUSE && busy_reg) else $error("protection lost");
  nak_busy_a: assert property (@(posedge i_scl) disable iff (!i_rst_n)
    state_reg != sesp_pkg::LK_READ && cnt_reg == sesp_pkg::BIT_LAST && lin_s.busy && start_tog == seen_reg
    |=> !ack_reg ##1 !o_sda_oe) else $error("ack while busy");
  cs_match_a: assert property (@(posedge i_scl) disable iff (!i_rst_n)
    state_reg == sesp_pkg::LK_CTRL && cnt_reg == sesp_pkg::BIT_LAST && byte_in[3:1] != lin_s.cs
    && start_tog == seen_reg |=> !ack_reg) else $error("ack with foreign chip select");
  prot_read_a: assert property (@(posedge i_scl) disable iff (!i_rst_n)
    state_reg == sesp_pkg::LK_CTRL && cnt_reg == sesp_pkg::BIT_LAST && start_tog == seen_reg
    && byte_in[7:4] == sesp_pkg::CODE_PROT && byte_in[0] |=> !ack_reg) else $error("ack of protect read");
  page_wrap_a: assert property (@(posedge i_scl) disable iff (!i_rst_n)
    buf_we && start_tog == seen_reg |=> ptr_reg[7:4] == $past(ptr_reg[7:4])
    && ptr_reg[3:0] == 4'($past(ptr_reg[3:0]) + 4'h1)) else $error("page pointer step wrong");
  read_step_a: assert property (@(posedge i_scl) disable iff (!i_rst_n)
    state_reg != sesp_pkg::LK_READ ##1 state_reg == sesp_pkg::LK_READ |-> ptr_reg == 8'($past(ptr_reg) + 8'h01))
    else $error("read pointer not stepped");

  busy_seen_c: cover property (@(posedge i_clock) disable iff (!i_rst_n) $fell(busy_reg));
  swp_set_c: cover property (@(posedge i_clock) disable iff (!i_rst_n) $rose(swp_reg));
  seq_read_c: cover property (@(posedge i_scl) disable iff (!i_rst_n)
    state_reg == sesp_pkg::LK_READ && cnt_reg == sesp_pkg::BIT_ACK && !i_sda_in);
  page_full_c: cover property (@(posedge i_scl) disable iff (!i_rst_n) &pend_reg.mask);
endmodule // sesp_top

// *** tb/sesp_master.sv ***
// bus master model for the eeprom slave: start, stop, byte write and read
// assumes a pull-up resolves the data line; scl stands high outside frames
`timescale 1ns/1ns
module sesp_master (
  // resolved data line
  input wire logic i_sda,
  // master drive, high releases the line
  output logic o_scl,
  output logic o_sda
);
  localparam int Q = 12;
  initial begin
    o_scl = 1'b1;
    o_sda = 1'b1;
  end
  ////////////////////////////////////////////////////////////////////////////////
  // data moves only while scl is low; 48 ns per bit
  task automatic bit_io(input logic b, output logic r);
    #Q o_sda = b;
    #Q o_scl = 1'b1;
    #Q r = i_sda;
    #Q o_scl = 1'b0;
  endtask
  task automatic start();
    #Q o_sda = 1'b1;
    #Q o_scl = 1'b1;
    #Q o_sda = 1'b0;
    #Q o_scl = 1'b0;
  endtask
  // long tail keeps the bus free time between frames
  task automatic stop();
    #Q o_sda = 1'b0;
    #Q o_scl = 1'b1;
    #Q o_sda = 1'b1;
    #(20 * Q);
  endtask
  task automatic wbyte(input logic [7:0] d, output logic nak);
    logic r;
    for (int i = 7; i >= 0; i--) begin
      bit_io(d[i], r);
    end
    bit_io(1'b1, nak);
  endtask
  task automatic rbyte(input logic last, output logic [7:0] d);
    logic r;
    for (int i = 7; i >= 0; i--) begin
      bit_io(1'b1, r);
      d[i] = r;
    end
    bit_io(last, r);
  endtask
endmodule // sesp_master

// *** tb/sesp_top_bench.sv ***
// self-checking bench for the eeprom slave command logic
// assumes the master model and a pull-up on the data line
`timescale 1ns/1ns
module sesp_top_bench;
  localparam int PROG = 40;
  localparam logic [3:0] MEM = 4'h5;
  localparam logic [2:0] CS = 3'b101;
  logic i_clock, i_rst_n, scl, m_sda, sda, sda_out, sda_oe;
  logic wp, hv, busy, swp, nak;
  logic [7:0] got [0:15];
  logic [7:0] pg [0:15];
  int n_fail = 0;
  int n_compared = 0;
  int cyc = 0;
  int blen = 0;
  assign sda = m_sda & (sda_oe ? sda_out : 1'b1);
  sesp_master master (.i_sda(sda), .o_scl(scl), .o_sda(m_sda));
  sesp_top #(.MEM_CODE(MEM), .PROG_CYCLES(PROG)) uut (.i_clock(i_clock), .i_rst_n(i_rst_n), .i_scl(scl),
    .i_sda_in(sda), .o_sda_out(sda_out), .o_sda_oe(sda_oe), .i_chip_select_bit0(CS[0]),
    .i_chip_select_bit1(CS[1]), .i_chip_select_bit2(CS[2]), .i_write_protect(wp),
    .i_wp_high_voltage(hv), .o_busy(busy), .o_sw_protect(swp));
  initial begin
    i_clock = 1'b0;
    forever #25 i_clock = ~i_clock;
  end
  always @(posedge i_clock) begin
    cyc <= cyc + 1;
    if (busy === 1'b1) begin
      blen <= blen + 1;
    end
    if (cyc == 20000) begin
      n_fail++;
      final_report();
    end
  end
  ////////////////////////////////////////////////////////////////////////////////
  task automatic final_report();
    $display("compared %0d mismatches %0d", n_compared, n_fail);
    if (n_fail == 0 && n_compared > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    n_compared++;
    if (seen !== exp) begin
      n_fail++;
      $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  function automatic logic [7:0] ctl(input logic [3:0] code, input logic rw);
    return {code, CS, rw};
  endfunction
  // polls until acked; a poll inside the cycle must be refused
  task automatic wait_done();
    int i;
    for (i = 0; i < 20 && busy !== 1'b1; i++) @(negedge i_clock);
    master.start();
    master.wbyte(ctl(MEM, 1'b0), nak);
    master.stop();
    chk(nak, 1'b1);
    for (i = 0; i < 20; i++) begin
      master.start();
      master.wbyte(ctl(MEM, 1'b0), nak);
      master.stop();
      if (nak === 1'b0) break;
    end
    chk(nak, 1'b0);
    chk(busy, 1'b0);
    chk(16'(blen), 16'(PROG));
  endtask
  task automatic wframe(input logic [3:0] code, input logic [7:0] a, input logic [7:0] d, input int n);
    blen = 0;
    master.start();
    master.wbyte(ctl(code, 1'b0), nak);
    chk(nak, 1'b0);
    master.wbyte(a, nak);
    chk(nak, 1'b0);
    for (int k = 0; k < n; k++) begin
      master.wbyte(d + 8'(k), nak);
      chk(nak, 1'b0);
    end
    master.stop();
    wait_done();
  endtask
  // a refused control byte: the following byte is ignored too
  task automatic refuse(input logic [7:0] c);
    master.start();
    master.wbyte(c, nak);
    chk(nak, 1'b1);
    master.wbyte(8'h00, nak);
    chk(nak, 1'b1);
    master.stop();
  endtask
  task automatic rd(input logic [7:0] a, input int n);
    master.start();
    master.wbyte(ctl(MEM, 1'b0), nak);
    master.wbyte(a, nak);
    master.start();
    master.wbyte(ctl(MEM, 1'b1), nak);
    chk(nak, 1'b0);
    for (int k = 0; k < n; k++) begin
      master.rbyte(k == n - 1, got[k]);
    end
    master.stop();
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  // eighteen bytes on purpose: the first two get overwritten
  task automatic t_page();
    wframe(MEM, 8'h02, 8'h40, 18);
    for (int k = 0; k < 18; k++) begin
      pg[(2 + k) % 16] = 8'h40 + 8'(k);
    end
    rd(8'h00, 15);
    for (int k = 0; k < 15; k++) begin
      chk(got[k], pg[k]);
    end
    master.start();
    master.wbyte(ctl(MEM, 1'b1), nak);
    master.rbyte(1'b1, got[0]);
    master.stop();
    chk(got[0], pg[15]);
  endtask
  task automatic t_byte();
    wframe(MEM, 8'h85, 8'h3c, 1);
    rd(8'h85, 1);
    chk(got[0], 8'h3c);
  endtask
  task automatic t_refuse();
    refuse({MEM, 3'b100, 1'b0});
    refuse({4'h3, CS, 1'b0});
    refuse(ctl(sesp_pkg::CODE_PROT, 1'b1));
    refuse(ctl(sesp_pkg::CODE_FUSE, 1'b1));
  endtask
  task automatic t_restart();
    master.start();
    master.wbyte(ctl(MEM, 1'b0), nak);
    master.wbyte(8'h85, nak);
    master.wbyte(8'h77, nak);
    rd(8'h85, 1);
    repeat (4) @(negedge i_clock);
    chk(busy, 1'b0);
    chk(got[0], 8'h3c);
  endtask
  task automatic t_hwp();
    wp = 1'b1;
    repeat (8) @(negedge i_clock);
    wframe(MEM, 8'h85, 8'h11, 1);
    wframe(sesp_pkg::CODE_PROT, 8'h00, 8'h00, 1);
    chk(swp, 1'b0);
    wp = 1'b0;
    rd(8'h85, 1);
    chk(got[0], 8'h3c);
  endtask
  task automatic t_swp();
    wframe(sesp_pkg::CODE_PROT, 8'h5a, 8'ha5, 1);
    chk(swp, 1'b1);
    refuse(ctl(sesp_pkg::CODE_PROT, 1'b0));
    wframe(MEM, 8'h02, 8'h99, 1);
    wframe(MEM, 8'h85, 8'h5a, 1);
    rd(8'h02, 1);
    chk(got[0], pg[2]);
    rd(8'h85, 1);
    chk(got[0], 8'h5a);
  endtask
  task automatic t_fuse();
    refuse(ctl(sesp_pkg::CODE_FUSE, 1'b0));
    hv = 1'b1;
    wframe(sesp_pkg::CODE_FUSE, 8'h00, 8'h00, 1);
    hv = 1'b0;
    chk(swp, 1'b0);
    wframe(MEM, 8'h02, 8'h99, 1);
    rd(8'h02, 1);
    chk(got[0], 8'h99);
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  // reset must see a start, four clock pulses and a stop on the bus to clear the link side
  initial begin
    i_rst_n = 1'b0;
    wp = 1'b0;
    hv = 1'b0;
    master.start();
    for (int i = 0; i < 4; i++) begin
      master.bit_io(1'b1, nak);
    end
    master.stop();
    @(negedge i_clock);
    i_rst_n = 1'b1;
    repeat (4) @(negedge i_clock);
    t_page();
    t_byte();
    t_refuse();
    t_restart();
    t_hwp();
    t_swp();
    t_fuse();
    final_report();
  end
endmodule // sesp_top_bench
